/* core/tap_thermal_alarm.v */
// Thermal alarm pin control: input timing, fan full_speed_on_alarm, output alarm,
// pin selection and speed-sense grouping, behind an Avalon-MM slave.
// Assumes temperatures arrive in quarter-degree units once per
// monitoring cycle marked by mon_cycle, and that the pin is pulled up.
//
// The Avalon-MM interface to the registers is this design's own decision.
`include "tap_consts.vh"
module tap_thermal_alarm #(
	parameter TICK_CYC = `TAP_TICK_CYC
) (
	input wire clk_sys,
	input wire rst,
	input wire [7:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	input wire pin_default_in,
	output reg pin_default_oe,
	output reg pin_default_out,
	input wire pin_alt_in,
	output reg pin_alt_oe,
	output reg pin_alt_out,
	input wire [29:0] temp_in,
	input wire mon_cycle,
	input wire [23:0] duty_in,
	input wire [2:0] fan_running,
	output reg [23:0] duty_out,
	output reg [3:0] speed_sense_four_used_q,
	output reg [7:0] sense_group_q,
	output reg smbalert_q,
	output reg irq_q
);
	reg [7:0] cfg_q [0:2];
	reg [7:0] crit_q [0:2];
	reg [7:0] acou1_q, mask2_q, cfg3_q, cfg4_q, lim_q, tmr_q;
	reg [2:0] stat_q, irq_en_q;
	reg lim_stat_q;
	reg [2:0] s_def_q, s_alt_q;
	reg asserted_q, asserted_prev_q;
	reg [31:0] tick_q;
	reg [2:0] over_q;
	reg out_low_q, held_q;
	reg rd_pend_q;
	reg [3:0] own_q;
	reg one_tick_q;
	wire own_drv = out_low_q | (|own_q);
	wire alarm_en = cfg3_q[`TAP_BIT_ENABLE];
	wire pin_sel = alarm_en & cfg4_q[`TAP_BIT_PIN_SEL];
	wire acc = (avs_read | avs_write) & avs_waitrequest;
	// Write lands at the edge that completes the transfer
	wire wr = avs_write & ~avs_waitrequest;
	wire tmr_rd = avs_read & avs_waitrequest &
		(avs_address == `TAP_OFF_ALARM_TMR);
	wire [2:0] over_now;
	wire lim_hit;
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_ch
			assign over_now[g] = cfg_q[g][`TAP_BIT_CH_ALARM_OUT] &
				(temp_in[g*10 +: 10] > {crit_q[g], 2'b00});
		end
	endgenerate
	// Zero limit: first assertion; else exceed
	assign lim_hit = (lim_q == 8'h00) ? (tmr_q != 8'h00) : (tmr_q > lim_q);
	// Sampled pin: three flops, change taken once last two agree
	always @(posedge clk_sys) begin
		if (rst) begin
			s_def_q <= 3'b111;
			s_alt_q <= 3'b111;
			own_q <= 4'h0;
			asserted_q <= 1'b0;
		end else begin
			s_def_q <= {s_def_q[1:0], pin_default_in};
			s_alt_q <= {s_alt_q[1:0], pin_alt_in};
			// Own drive still echoes through the sampling flops
			own_q <= {own_q[2:0], out_low_q};
			// Monitor only the selected pin when enabled
			if (!alarm_en)
				asserted_q <= 1'b0;
			else if (pin_sel && s_alt_q[2] == s_alt_q[1])
				asserted_q <= ~s_alt_q[2] & ~own_drv;
			else if (!pin_sel && s_def_q[2] == s_def_q[1])
				asserted_q <= ~s_def_q[2] & ~own_drv;
		end
	end
	// Cumulative timer: LSB set on first assertion, saturates, read clears all but LSB, which takes asserted_q
	always @(posedge clk_sys) begin
		if (rst) begin
			tmr_q <= 8'h00;
			tick_q <= 32'h00000000;
			one_tick_q <= 1'b0;
			asserted_prev_q <= 1'b0;
		end else begin
			asserted_prev_q <= asserted_q;
			if (tmr_rd) begin
				tmr_q <= {7'h00, asserted_q};
				tick_q <= 32'h00000000;
				one_tick_q <= 1'b0;
			end else if (asserted_q) begin
				if (!asserted_prev_q && tmr_q == 8'h00)
					tmr_q <= 8'h01;
				if (tick_q == TICK_CYC - 1) begin
					tick_q <= 32'h00000000;
					// Bit 0 alone stands for the first two ticks
					if (!one_tick_q)
						one_tick_q <= 1'b1;
					else if (tmr_q != 8'hFF)
						tmr_q <= tmr_q + 8'h01;
				end else begin
					tick_q <= tick_q + 32'h00000001;
				end
			end
		end
	end
	// Output alarm, evaluated once per monitoring cycle
	always @(posedge clk_sys) begin
		if (rst) begin
			over_q <= 3'b000;
			out_low_q <= 1'b0;
			held_q <= 1'b0;
		end else if (mon_cycle) begin
			over_q <= over_now;
			out_low_q <= alarm_en & (|over_now);
			held_q <= out_low_q;
		end
	end
	// Register bus slave, one wait state
	always @(posedge clk_sys) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
			rd_pend_q <= 1'b0;
		end else begin
			avs_waitrequest <= ~(acc & ~rd_pend_q) | ~avs_waitrequest;
			rd_pend_q <= acc & ~rd_pend_q;
			if (avs_read && avs_waitrequest) begin
				case (avs_address)
				`TAP_OFF_R1_CFG: avs_readdata <= {24'h0, cfg_q[0]};
				`TAP_OFF_LOC_CFG: avs_readdata <= {24'h0, cfg_q[1]};
				`TAP_OFF_R2_CFG: avs_readdata <= {24'h0, cfg_q[2]};
				`TAP_OFF_ACOU1: avs_readdata <= {24'h0, acou1_q};
				`TAP_OFF_R1_CRIT: avs_readdata <= {24'h0, crit_q[0]};
				`TAP_OFF_LOC_CRIT: avs_readdata <= {24'h0, crit_q[1]};
				`TAP_OFF_R2_CRIT: avs_readdata <= {24'h0, crit_q[2]};
				`TAP_OFF_MASK2: avs_readdata <= {24'h0, mask2_q};
				`TAP_OFF_CFG3: avs_readdata <= {24'h0, cfg3_q};
				`TAP_OFF_CFG4: avs_readdata <= {24'h0, cfg4_q};
				`TAP_OFF_ALARM_TMR: avs_readdata <= {24'h0, tmr_q};
				`TAP_OFF_ALARM_LIM: avs_readdata <= {24'h0, lim_q};
				`TAP_OFF_IRQ_STAT: avs_readdata <= {29'h0, stat_q};
				`TAP_OFF_IRQ_EN: avs_readdata <= {29'h0, irq_en_q};
				`TAP_OFF_FAN_STAT: avs_readdata <=
					{26'h0, lim_stat_q, over_q, held_q, asserted_q};
				default: avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end
	// Writable registers
	always @(posedge clk_sys) begin
		if (rst) begin
			cfg_q[0] <= `TAP_RST_REG;
			cfg_q[1] <= `TAP_RST_REG;
			cfg_q[2] <= `TAP_RST_REG;
			crit_q[0] <= `TAP_RST_CRIT;
			crit_q[1] <= `TAP_RST_CRIT;
			crit_q[2] <= `TAP_RST_CRIT;
			acou1_q <= `TAP_RST_REG;
			mask2_q <= `TAP_RST_REG;
			cfg3_q <= `TAP_RST_REG;
			cfg4_q <= `TAP_RST_REG;
			lim_q <= `TAP_RST_LIM;
			irq_en_q <= 3'b000;
		end else if (wr) begin
			case (avs_address)
			`TAP_OFF_R1_CFG: cfg_q[0] <= avs_writedata[7:0];
			`TAP_OFF_LOC_CFG: cfg_q[1] <= avs_writedata[7:0];
			`TAP_OFF_R2_CFG: cfg_q[2] <= avs_writedata[7:0];
			`TAP_OFF_ACOU1: acou1_q <= avs_writedata[7:0];
			`TAP_OFF_R1_CRIT: crit_q[0] <= avs_writedata[7:0];
			`TAP_OFF_LOC_CRIT: crit_q[1] <= avs_writedata[7:0];
			`TAP_OFF_R2_CRIT: crit_q[2] <= avs_writedata[7:0];
			`TAP_OFF_MASK2: mask2_q <= avs_writedata[7:0];
			`TAP_OFF_CFG3: cfg3_q <= avs_writedata[7:0];
			`TAP_OFF_CFG4: cfg4_q <= avs_writedata[7:0];
			`TAP_OFF_ALARM_LIM: lim_q <= avs_writedata[7:0];
			`TAP_OFF_IRQ_EN: irq_en_q <= avs_writedata[2:0];
			default: ;
			endcase
		end
	end
	// Sticky status; set wins over clear
	always @(posedge clk_sys) begin
		if (rst) begin
			stat_q <= 3'b000;
			lim_stat_q <= 1'b0;
			irq_q <= 1'b0;
			smbalert_q <= 1'b0;
		end else begin
			// Limit status sticky, cleared by writing one
			if (lim_hit)
				lim_stat_q <= 1'b1;
			else if (wr && avs_address == `TAP_OFF_FAN_STAT &&
				avs_writedata[5])
				lim_stat_q <= 1'b0;
			stat_q <= (stat_q & ~((wr && avs_address == `TAP_OFF_IRQ_CLR) ?
				avs_writedata[2:0] : 3'b000)) |
				{out_low_q, asserted_q & ~asserted_prev_q, lim_hit};
			irq_q <= |(stat_q & irq_en_q);
			// Mask suppresses alert, status still set
			smbalert_q <= lim_stat_q & ~mask2_q[`TAP_BIT_LIM_MASK];
		end
	end
	// Pin drivers, fan full_speed_on_alarm, grouping
	always @(posedge clk_sys) begin
		if (rst) begin
			pin_default_oe <= 1'b0;
			pin_default_out <= 1'b0;
			pin_alt_oe <= 1'b0;
			pin_alt_out <= 1'b0;
			speed_sense_four_used_q <= 4'h0;
			sense_group_q <= 8'h00;
		end else begin
			pin_default_oe <= out_low_q & ~pin_sel;
			pin_alt_oe <= out_low_q & pin_sel;
			pin_default_out <= 1'b0;
			pin_alt_out <= 1'b0;
			// Default pin freed for sense four
			speed_sense_four_used_q <= {~(alarm_en & ~pin_sel), 3'b111};
			// Sync groups two-four on drive two
			if (acou1_q[`TAP_BIT_SYNC])
				sense_group_q <= 8'h54;
			else
				sense_group_q <= 8'hA4;
		end
	end
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_fan
			always @(posedge clk_sys) begin
				if (rst)
					duty_out[g*8 +: 8] <= 8'h00;
				else if (cfg3_q[`TAP_BIT_FULL_SPEED_ON_ALARM] && asserted_q &&
					fan_running[g] && duty_in[g*8 +: 8] != 8'h00)
					duty_out[g*8 +: 8] <= 8'hFF;
				else
					duty_out[g*8 +: 8] <= duty_in[g*8 +: 8];
			end
		end
	endgenerate
endmodule

/* core/tap_consts.vh */
// Register offsets, field positions, reset values and timing counts
// for the thermal alarm pin control block.
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH
`define TAP_OFF_R1_CFG 8'h5F
`define TAP_OFF_LOC_CFG 8'h60
`define TAP_OFF_R2_CFG 8'h61
`define TAP_OFF_ACOU1 8'h62
`define TAP_OFF_R1_CRIT 8'h6A
`define TAP_OFF_LOC_CRIT 8'h6B
`define TAP_OFF_R2_CRIT 8'h6C
`define TAP_OFF_MASK2 8'h75
`define TAP_OFF_CFG3 8'h78
`define TAP_OFF_CFG4 8'h7D
`define TAP_OFF_ALARM_TMR 8'h79
`define TAP_OFF_ALARM_LIM 8'h7A
`define TAP_OFF_IRQ_STAT 8'h90
`define TAP_OFF_IRQ_CLR 8'h91
`define TAP_OFF_IRQ_EN 8'h92
`define TAP_OFF_FAN_STAT 8'h93
`define TAP_BIT_CH_ALARM_OUT 3
`define TAP_BIT_ENABLE 1
`define TAP_BIT_FULL_SPEED_ON_ALARM 2
`define TAP_BIT_PIN_SEL 1
`define TAP_BIT_LIM_MASK 5
`define TAP_BIT_SYNC 4
`define TAP_RST_REG 8'h00
`define TAP_RST_CRIT 8'h64
`define TAP_RST_LIM 8'h00
`define TAP_IRQ_LIM 0
`define TAP_IRQ_IN 1
`define TAP_IRQ_OUT 2
`define TAP_TICK_US 22760
`define TAP_TICK_CYC (`TAP_TICK_US * 50)
`endif

/* tb/tap_trip.sv */
// Trip sensor on the alarm pins: pulls the selected pin low on demand.
// Both pins have a pull-up, so a released pin reads high.
module tap_trip (
	input wire pull_lo,
	input wire sel_alt,
	input wire pin_default_oe,
	input wire pin_alt_oe,
	output wire pin_default_in,
	output wire pin_alt_in
);
	timeunit 1ns / 1ns;
	assign pin_default_in = !(pin_default_oe || (pull_lo && !sel_alt));
	assign pin_alt_in = !(pin_alt_oe || (pull_lo && sel_alt));
endmodule

/* tb/tap_chk.sv */
// Checker on the alarm block ports.
// Bound to every instance of tap_thermal_alarm.
module tap_chk (
	input wire clk_sys,
	input wire rst,
	input wire avs_read,
	input wire avs_write,
	input wire avs_waitrequest,
	input wire pin_default_oe,
	input wire pin_default_out,
	input wire pin_alt_oe,
	input wire pin_alt_out,
	input wire mon_cycle,
	input wire [23:0] duty_in,
	input wire [2:0] fan_running,
	input wire [23:0] duty_out
);
	timeunit 1ns / 1ns;
	wire oe = pin_default_oe | pin_alt_oe;
	reg mon_q;
	// Set once a monitoring cycle passes while the pin is driven
	always @(posedge clk_sys) begin
		if (rst || !oe)
			mon_q <= 1'b0;
		else if (mon_cycle)
			mon_q <= 1'b1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("long answer");
	chk_answer_next: assert property ((avs_read || avs_write) &&
		avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
	chk_out_low: assert property (!pin_default_out && !pin_alt_out)
		else $error("pin driven high");
	chk_one_pin: assert property (!(pin_default_oe && pin_alt_oe))
		else $error("both pins");
	chk_rise_mon: assert property ($rose(oe) |-> $past(mon_cycle, 2))
		else $error("rise off cycle");
	chk_fall_mon: assert property ($fell(oe) |-> $past(mon_cycle, 2))
		else $error("fall off cycle");
	chk_hold_cycle: assert property ($fell(oe) |-> mon_q)
		else $error("alarm too short");
	chk_fan_idle: assert property (!fan_running[1] && $stable(duty_in)
		&& $stable(fan_running) && !$past(rst) |->
		duty_out[15:8] == duty_in[15:8]) else $error("idle fan changed");
endmodule

/* tb/tap_thermal_alarm_tb.sv */
// Bench for the alarm block: registers, grouping, pin alarm, full_speed_on_alarm,
// interrupts and limit alert; tap_trip drives the pins.
module tap_thermal_alarm_tb;
	timeunit 1ns / 1ns;
	logic clk_sys = 1'b0, rst = 1'b1, mon_cycle = 1'b0, pull_lo = 1'b0;
	logic avs_read = 1'b0, avs_write = 1'b0, sel_alt = 1'b0;
	logic avs_waitrequest, irq_q, smbalert_q, pin_alt_in, pin_alt_oe;
	logic pin_default_in, pin_default_oe, pin_default_out, pin_alt_out;
	logic [7:0] avs_address = 8'h00, q, sense_group_q;
	logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
	logic [29:0] temp_in = {10'h000, 10'h3FF, 10'h000};
	logic [23:0] duty_in = 24'h403020, duty_out;
	logic [3:0] speed_sense_four_used_q, mc = 4'h0;
	logic [2:0] fan_running = 3'b101;
	int err_total = 0, checked = 0;
	// Offset, reset value, write data, readback
	logic [31:0] rows [11] = '{32'h5F000808, 32'h60000000, 32'h61000808,
		32'h62001010, 32'h6A641010, 32'h6B647F7F, 32'h6C641010,
		32'h75002020, 32'h78000202, 32'h7D000000, 32'h40005A00};
	tap_thermal_alarm #(.TICK_CYC(20)) tap_thermal_alarm_i (
		.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.pin_default_in(pin_default_in), .pin_default_oe(pin_default_oe),
		.pin_default_out(pin_default_out), .pin_alt_in(pin_alt_in),
		.pin_alt_oe(pin_alt_oe), .pin_alt_out(pin_alt_out),
		.temp_in(temp_in), .mon_cycle(mon_cycle), .duty_in(duty_in),
		.fan_running(fan_running), .duty_out(duty_out),
		.speed_sense_four_used_q(speed_sense_four_used_q),
		.sense_group_q(sense_group_q), .smbalert_q(smbalert_q),
		.irq_q(irq_q)
	);
	tap_trip tap_trip_i (
		.pull_lo(pull_lo), .sel_alt(sel_alt),
		.pin_default_oe(pin_default_oe), .pin_alt_oe(pin_alt_oe),
		.pin_default_in(pin_default_in), .pin_alt_in(pin_alt_in)
	);
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		mc <= (mc == 4'h9) ? 4'h0 : mc + 4'h1;
		mon_cycle <= (mc == 4'h9);
	end
	task automatic bus(input logic w, input logic [7:0] a, d);
		{avs_write, avs_read, avs_address} <= {w, !w, a};
		avs_writedata <= {24'h000000, d};
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		{avs_write, avs_read} <= 2'b00;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic cmp(input string s, input logic [31:0] e, g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic pull(input logic v, input int c);
		pull_lo <= v;
		repeat (c) @(posedge clk_sys);
	endtask
	task automatic report_and_stop();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge clk_sys);
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		foreach (rows[i]) begin
			bus(1'b0, rows[i][31:24], 8'h00);
			cmp("reset", rows[i][23:16], q);
			bus(1'b1, rows[i][31:24], rows[i][15:8]);
			bus(1'b0, rows[i][31:24], 8'h00);
			cmp("rdbk", rows[i][7:0], q);
		end
		cmp("grp", 8'h54, sense_group_q);
		cmp("free", 4'h7, speed_sense_four_used_q);
		bus(1'b1, 8'h62, 8'h00);
		cmp("grp", 8'hA4, sense_group_q);
		bus(1'b1, 8'h7D, 8'h02);
		sel_alt <= 1'b1;
		temp_in[9:0] <= 10'h041;
		pull(1'b0, 25);
		cmp("free", 1'b1, speed_sense_four_used_q[3]);
		cmp("pins", 3'b100, {pin_alt_oe, pin_default_oe, pin_alt_in});
		cmp("pinout", 2'b00, {pin_alt_out, pin_default_out});
		temp_in[9:0] <= 10'h040;
		pull(1'b0, 25);
		cmp("pins", 3'b001, {pin_alt_oe, pin_default_oe, pin_alt_in});
		bus(1'b1, 8'h7D, 8'h00);
		sel_alt <= 1'b0;
		bus(1'b1, 8'h91, 8'h07);
		bus(1'b1, 8'h78, 8'h06);
		pull(1'b1, 8);
		cmp("duty", 24'hFF30FF, duty_out);
		bus(1'b0, 8'h93, 8'h00);
		cmp("mask", 2'b10, {q[5], smbalert_q});
		pull(1'b0, 8);
		cmp("duty", 24'h403020, duty_out);
		bus(1'b0, 8'h90, 8'h00);
		cmp("irq", 8'h03, q);
		bus(1'b1, 8'h92, 8'h01);
		cmp("irq", 1'b1, irq_q);
		bus(1'b1, 8'h92, 8'h00);
		cmp("irq", 1'b0, irq_q);
		bus(1'b0, 8'h79, 8'h00);
		bus(1'b1, 8'h93, 8'h20);
		bus(1'b1, 8'h91, 8'h07);
		bus(1'b0, 8'h90, 8'h00);
		cmp("irq", 8'h00, q);
		bus(1'b1, 8'h75, 8'h00);
		bus(1'b1, 8'h7A, 8'h01);
		pull(1'b1, 30);
		cmp("alert", 1'b0, smbalert_q);
		pull(1'b1, 30);
		cmp("alert", 1'b1, smbalert_q);
		// Mid-run reset with the pin still pulled low
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		cmp("rst", 3'b100, {avs_waitrequest, smbalert_q, irq_q});
		bus(1'b0, 8'h78, 8'h00);
		cmp("rst", 8'h00, q);
		cmp("duty", 24'h403020, duty_out);
		report_and_stop();
	end
endmodule
bind tap_thermal_alarm tap_chk tap_chk_i (
	.clk_sys(clk_sys), .rst(rst), .avs_read(avs_read),
	.avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
	.pin_default_oe(pin_default_oe), .pin_default_out(pin_default_out),
	.pin_alt_oe(pin_alt_oe), .pin_alt_out(pin_alt_out),
	.mon_cycle(mon_cycle), .duty_in(duty_in), .fan_running(fan_running),
	.duty_out(duty_out)
);
